// ---- hw/card_regs_pkg.sv ----
// Constants, field layouts and frame carriers for the card register bank.
// Assumes a 25 MHz system clock and a command bus clocked by the host.
package card_regs_pkg;

  // Command and response frame sizes, in link bits
  localparam int CMD_BITS = 48;
  localparam int SHORT_BITS = 48;
  localparam int LONG_BITS = 136;
  localparam int RESP_GAP = 2; // Link clocks between command end bit and response start

  // Command indices that this bank decodes
  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_SEND_OP = 6'h01;
  localparam logic [5:0] CMD_ALL_CID = 6'h02;
  localparam logic [5:0] CMD_SET_ADDR = 6'h03;
  localparam logic [5:0] CMD_SET_DRV = 6'h04;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_SEND_CSD = 6'h09;
  localparam logic [5:0] CMD_SEND_CID = 6'h0a;
  localparam logic [5:0] CMD_STATUS = 6'h0d;
  localparam logic [5:0] CMD_PROG_CSD = 6'h1b;

  // Power-up routine length
  localparam int POWERUP_US = 1000;
  localparam int SYS_MHZ = 25;
  localparam int POWERUP_CYCLES = POWERUP_US * SYS_MHZ;

  // Operating-conditions layout
  localparam logic [1:0] ACCESS_BYTE = 2'h0;
  localparam logic [1:0] ACCESS_SECTOR = 2'h2;
  localparam logic [8:0] OCR_HIGH_WINDOW = 9'h1ff;
  localparam logic [6:0] OCR_MID_WINDOW = 7'h00;
  localparam logic OCR_LOW_WINDOW = 1'b1;

  // Reset values of writable registers, and the broadcast relative address
  localparam logic [15:0] DRIVER_STAGE_RESET = 16'h0404;
  localparam logic [15:0] REL_ADDR_RESET = 16'h0001;
  localparam logic [15:0] REL_ADDR_BROADCAST = 16'h0000;
  localparam logic [14:0] CSD_PROG_RESET = 15'h0000;

  // Identity fields; these values are arbitrary
  localparam logic [7:0] MAKER_CODE = 8'h5a;
  localparam logic [1:0] DEVICE_PACKAGE_KIND = 2'h1;
  localparam logic [7:0] OEM_APPLICATION_CODE = 8'h3c;
  localparam logic [47:0] PRODUCT_NAME = 48'h4e_41_4e_44_30_31;
  localparam logic [7:0] PRODUCT_REVISION = 8'h10;
  localparam logic [7:0] MANUFACTURING_DATE = 8'h00;

  // Card-specific-data read-only part, bits 127 down to 16
  localparam logic [111:0] CSD_FIXED = {
    2'h3, 4'h4, 2'h0,          // Structure, spec_version, reserved
    8'hff, 8'hff,              // read_access_time, read_access_cycles
    8'h32, 12'h1f5, 4'h9,      // Transfer rate, command_class_set, max_read_block_length
    1'b0, 1'b0, 1'b0, 1'b0,    // partial_read, write_misalign, read_misalign, driver_stage_present
    2'h0, 12'hfff,             // Reserved, device size
    3'h3, 3'h7, 3'h3, 3'h7,    // Current classes
    3'h7, 5'h1f, 5'h1c,        // device_size_multiplier, erase_group_size, erase_group_multiplier
    5'h00, 1'b1,               // protect_group_size, protect_group_enable
    2'h0, 3'h2, 4'h9, 1'b0,    // Default ECC, write_speed_factor, max_write_block_length, partial_write
    4'h0, 1'b0                 // Reserved, content protection
  };

  // Card status layout
  localparam int STATUS_STATE_LSB = 9;
  localparam int STATUS_READY_BIT = 8;

  typedef enum logic [2:0] {StIdle, StReady, StIdent, StStandby, StTransfer} card_state_e;

  // Decoded command frame
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } cmd_frame_s;

endpackage

// ---- hw/managed_nand_card_registers.sv ----
// Card register bank behind the command line of a managed NAND device.
// Assumes the host clock and command pin arrive asynchronously and the
// host clock is at least eight system clocks long.
`timescale 1ns/100ps
module managed_nand_card_registers
  import card_regs_pkg::*;
#(
  parameter int POWERUP_COUNT = POWERUP_CYCLES, // Shorten for simulation
  parameter logic [31:0] PRODUCT_SERIAL = 32'h0000_0001 // Distinct per instance
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic cmdIn,
  output logic cmdOut,
  output logic cmdOeN,
  output logic powerUpDone,
  output logic [2:0] cardState,
  output logic [15:0] relativeAddress,
  output logic [15:0] driverStage
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Serial checksum over the top len bits of data
  function automatic logic [6:0] crc7(input logic [119:0] data, input int len);
    logic [6:0] crc;
    logic fb;
    crc = 7'h00;
    fb = 1'b0;
    for (int i = 119; i >= 0; i--) begin
      if (i >= 120 - len) begin
        fb = data[i] ^ crc[6];
        crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
    end
    return crc;
  endfunction

  // True when an addressed command targets this card
  function automatic logic addrHit(input cmd_frame_s f, input logic [15:0] relative_address);
    return f.arg[31:16] == relative_address;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link edges

  logic clkS1_q, clkS2_q, clkS3_q; // Link clock sync chain plus history
  logic cmdS1_q, cmdS2_q; // Command pin sync chain
  logic linkRise, linkFall;

  // Two flops per pin before any logic looks at it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkS1_q <= 1'b0;
      clkS2_q <= 1'b0;
      clkS3_q <= 1'b0;
      cmdS1_q <= 1'b1;
      cmdS2_q <= 1'b1;
    end else begin
      clkS1_q <= linkClk;
      clkS2_q <= clkS1_q;
      clkS3_q <= clkS2_q;
      cmdS1_q <= cmdIn;
      cmdS2_q <= cmdS1_q;
    end
  end

  assign linkRise = clkS2_q & ~clkS3_q;
  assign linkFall = ~clkS2_q & clkS3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up routine

  logic [31:0] powerCnt_q;
  logic powerDone_q;

  // Busy stays low until the count runs out
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      powerCnt_q <= 32'h0;
      powerDone_q <= 1'b0;
    end else if (!powerDone_q) begin
      powerCnt_q <= powerCnt_q + 32'h1;
      powerDone_q <= (powerCnt_q >= 32'(POWERUP_COUNT - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command receiver

  logic rxBusy_q;
  logic [5:0] rxCnt_q;
  logic [47:0] rxShift_q;
  logic frameDone_q; // One-cycle pulse when a whole frame sits in rxShift_q
  logic txBusy_q;
  logic [47:0] rxFull;

  assign rxFull = {rxShift_q[46:0], cmdS2_q};

  // Sample on host clock rises; the line is ignored while we answer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxBusy_q <= 1'b0;
      rxCnt_q <= 6'h0;
      rxShift_q <= 48'h0;
      frameDone_q <= 1'b0;
    end else begin
      frameDone_q <= 1'b0;
      if (linkRise) begin
        if (!rxBusy_q) begin
          // Start bit opens a frame
          if (!cmdS2_q && !txBusy_q) begin
            rxBusy_q <= 1'b1;
            rxCnt_q <= 6'h1;
            rxShift_q <= rxFull;
          end
        end else begin
          rxShift_q <= rxFull;
          rxCnt_q <= rxCnt_q + 6'h1;
          if (rxCnt_q == 6'(CMD_BITS - 1)) begin
            rxBusy_q <= 1'b0;
            frameDone_q <= 1'b1;
          end
        end
      end
    end
  end

  cmd_frame_s frame;
  logic frameOk;

  // Host-direction bit, end bit and checksum must all agree
  assign frame = '{index: rxShift_q[45:40], arg: rxShift_q[39:8]};
  assign frameOk = rxShift_q[46] && rxShift_q[0] &&
    (rxShift_q[7:1] == crc7({rxShift_q[47:8], 80'h0}, 40));

  ////////////////////////////////////////////////////////////////////////////
  // Register contents

  card_state_e state_q;
  logic [15:0] rca_q;
  logic [15:0] dsr_q;
  logic [14:0] csdProg_q; // Host-programmable bits 15 down to 1
  logic [31:0] operating_conditions;
  logic [119:0] cidBody;
  logic [127:0] device_identity;
  logic [127:0] card_specific_data;
  logic [2:0] stateCode;
  logic [31:0] status;

  assign operating_conditions = {powerDone_q, ACCESS_SECTOR, 5'h00,
    OCR_HIGH_WINDOW, OCR_MID_WINDOW, OCR_LOW_WINDOW, 7'h00};
  assign cidBody = {MAKER_CODE, 6'h00, DEVICE_PACKAGE_KIND, OEM_APPLICATION_CODE,
    PRODUCT_NAME, PRODUCT_REVISION, PRODUCT_SERIAL, MANUFACTURING_DATE};
  assign device_identity = {cidBody, crc7(cidBody, 120), 1'b1};
  // Fixed part carries the capability and timing fields
  assign card_specific_data = {CSD_FIXED, csdProg_q, 1'b1};
  assign stateCode = 3'(state_q);
  assign status = {19'h0, 1'b0, stateCode, powerDone_q, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  card_state_e stateD;
  logic [135:0] respD;
  logic [7:0] respLenD;
  logic [47:0] shortFrame;
  logic [39:0] shortHead;

  // short answers carry the status before any state change
  assign shortHead = {2'b00, frame.index, status};
  assign shortFrame = {shortHead, crc7({shortHead, 80'h0}, 40), 1'b1};

  // Choose the answer and the next card state
  always_comb begin
    stateD = state_q;
    respD = 136'h0;
    respLenD = 8'h0;
    case (frame.index)
      CMD_SEND_OP: begin
        if (state_q == StIdle) begin
          respD = {2'b00, 6'h3f, operating_conditions, 7'h7f, 1'b1, 88'h0};
          respLenD = 8'(SHORT_BITS);
          if (powerDone_q) begin
            stateD = StReady;
          end
        end
      end
      CMD_ALL_CID: begin
        if (state_q == StReady) begin
          respD = {2'b00, 6'h3f, device_identity[127:1], 1'b1};
          respLenD = 8'(LONG_BITS);
          stateD = StIdent;
        end
      end
      CMD_SET_ADDR: begin
        if (state_q == StIdent) begin
          respD = {shortFrame, 88'h0};
          respLenD = 8'(SHORT_BITS);
          stateD = StStandby;
        end
      end
      CMD_SELECT: begin
        // Own address selects; any other, zero included, deselects
        if (state_q == StStandby && addrHit(frame, rca_q)) begin
          respD = {shortFrame, 88'h0};
          respLenD = 8'(SHORT_BITS);
          stateD = StTransfer;
        end else if (state_q == StTransfer && !addrHit(frame, rca_q)) begin
          stateD = StStandby;
        end
      end
      CMD_SEND_CSD, CMD_SEND_CID: begin
        if (state_q == StStandby && addrHit(frame, rca_q)) begin
          respD = {2'b00, 6'h3f, (frame.index == CMD_SEND_CSD) ? card_specific_data[127:1] : device_identity[127:1], 1'b1};
          respLenD = 8'(LONG_BITS);
        end
      end
      CMD_STATUS: begin
        if (state_q inside {StStandby, StTransfer} && addrHit(frame, rca_q)) begin
          respD = {shortFrame, 88'h0};
          respLenD = 8'(SHORT_BITS);
        end
      end
      CMD_PROG_CSD: begin
        if (state_q == StTransfer) begin
          respD = {shortFrame, 88'h0};
          respLenD = 8'(SHORT_BITS);
        end
      end
      default: begin
        stateD = state_q; // Unknown commands get no answer
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card state and writable registers

  // Only whole, checked frames change anything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= StIdle;
      rca_q <= REL_ADDR_RESET;
      dsr_q <= DRIVER_STAGE_RESET;
      csdProg_q <= CSD_PROG_RESET;
    end else if (frameDone_q && frameOk) begin
      if (frame.index == CMD_GO_IDLE) begin
        // Software reset back to identification start
        state_q <= StIdle;
        rca_q <= REL_ADDR_RESET;
      end else begin
        state_q <= stateD;
      end
      if (frame.index == CMD_SET_ADDR && state_q == StIdent) begin
        rca_q <= frame.arg[31:16];
      end
      if (frame.index == CMD_SET_DRV && state_q == StStandby) begin
        dsr_q <= frame.arg[31:16];
      end
      // Read-only fields have no storage, so only these bits can move
      if (frame.index == CMD_PROG_CSD && state_q == StTransfer) begin
        csdProg_q <= frame.arg[15:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response transmitter

  logic [135:0] txShift_q;
  logic [7:0] txLeft_q;
  logic [1:0] txGap_q;
  logic txDrive_q;

  // Waits the gap on rises, then drives one bit per host clock fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txBusy_q <= 1'b0;
      txShift_q <= 136'h0;
      txLeft_q <= 8'h0;
      txGap_q <= 2'h0;
      txDrive_q <= 1'b0;
    end else if (frameDone_q && frameOk && respLenD != 8'h0 && frame.index != CMD_GO_IDLE) begin
      txBusy_q <= 1'b1;
      txShift_q <= respD;
      txLeft_q <= respLenD;
      txGap_q <= 2'(RESP_GAP);
      txDrive_q <= 1'b0;
    end else if (txBusy_q) begin
      if (txGap_q != 2'h0) begin
        if (linkRise) begin
          txGap_q <= txGap_q - 2'h1;
        end
      end else if (linkFall) begin
        if (txLeft_q == 8'h0) begin
          // Last bit has stood a full clock; let go of the line
          txBusy_q <= 1'b0;
          txDrive_q <= 1'b0;
        end else begin
          txDrive_q <= 1'b1;
          txShift_q <= {txShift_q[134:0], 1'b1};
          txLeft_q <= txLeft_q - 8'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Pin bit is taken before the shift so it trails the shifter by one bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmdOut <= 1'b1;
      cmdOeN <= 1'b1;
      powerUpDone <= 1'b0;
      cardState <= 3'h0;
      relativeAddress <= REL_ADDR_RESET;
      driverStage <= DRIVER_STAGE_RESET;
    end else begin
      if (txBusy_q && txGap_q == 2'h0 && linkFall) begin
        cmdOut <= (txLeft_q == 8'h0) ? 1'b1 : txShift_q[135];
        cmdOeN <= (txLeft_q == 8'h0);
      end else if (!txBusy_q) begin
        cmdOut <= 1'b1;
        cmdOeN <= 1'b1;
      end
      powerUpDone <= powerDone_q;
      cardState <= stateCode;
      relativeAddress <= rca_q;
      driverStage <= dsr_q;
    end
  end

endmodule

// ---- test/card_regs_assertions.sv ----
// Port checker for the card register bank.
// Assumes it is bound into every instance of the bank.
`timescale 1ns/100ps
module card_regs_checker
  import card_regs_pkg::*;
#(
  parameter int POWERUP_COUNT = POWERUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic cmdIn,
  input wire logic cmdOut,
  input wire logic cmdOeN,
  input wire logic powerUpDone,
  input wire logic [2:0] cardState,
  input wire logic [15:0] relativeAddress,
  input wire logic [15:0] driverStage
);
  int upCnt_q; // Cycles since release, saturating
  // Counter instead of a long repetition keeps the tools fast
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upCnt_q <= 0;
    end else if (upCnt_q < POWERUP_COUNT + 8) begin
      upCnt_q <= upCnt_q + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_busy_early: assert property (upCnt_q < POWERUP_COUNT - 1 |-> !powerUpDone)
    else $error("power-up flag set too early");
  a_busy_late: assert property (upCnt_q >= POWERUP_COUNT + 3 |-> powerUpDone)
    else $error("power-up flag never set");
  a_ready_power: assert property (cardState == StReady |-> powerUpDone)
    else $error("ready state before power-up");
  a_rst_values: assert property ($fell(rst) |-> relativeAddress == 16'h0001 && driverStage == 16'h0404)
    else $error("register reset values wrong");
  a_addr_change: assert property (!$stable(relativeAddress) |-> $past(cardState) == StIdent || cardState == StIdle)
    else $error("address changed outside identification");
  a_drv_change: assert property (!$stable(driverStage) |-> $past(cardState) == StStandby)
    else $error("driver stage changed outside stand-by");
  a_line_idle: assert property (cmdOeN |-> cmdOut)
    else $error("released line not idle high");
  a_start_bit: assert property ($fell(cmdOeN) |-> !cmdOut)
    else $error("response does not open with start bit");
endmodule
bind managed_nand_card_registers card_regs_checker #(.POWERUP_COUNT(POWERUP_COUNT)) card_regs_checker_inst (
  .clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .cmdIn(cmdIn), .cmdOut(cmdOut), .cmdOeN(cmdOeN),
  .powerUpDone(powerUpDone), .cardState(cardState), .relativeAddress(relativeAddress), .driverStage(driverStage));

// ---- test/card_host_model.sv ----
// Behavioural host controller on the command line.
// Assumes the line has a pull-up; clock stands low between frames.
`timescale 1ns/100ps
module card_host_model (
  output logic linkClk,
  output logic cmdIn,
  input wire logic cmdOut,
  input wire logic cmdOeN
);
  logic hostOeN = 1'b1; // Low while host drives
  logic hostBit = 1'b1; // Host bit on the line
  initial linkClk = 1'b0;
  // Resolved wire, pull-up when nobody drives
  assign cmdIn = !cmdOeN ? cmdOut : (!hostOeN ? hostBit : 1'b1);
  ////////////////////////////////////////////////////////////
  // Checksum x^7 + x^3 + 1 over the low n bits, MSB first
  function automatic logic [6:0] crc7(input logic [127:0] d, input int n);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
    end
    return c;
  endfunction
  // One frame out, then up to nBits back; sampled late in the bit to absorb sync delay
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int nBits,
                      output logic [135:0] resp, output logic seen);
    logic [47:0] frame;
    int k;
    frame = {2'b01, idx, arg, 7'h00, 1'b1};
    frame[7:1] = crc7({88'h0, frame[47:8]}, 40);
    resp = '0;
    seen = 1'b0;
    hostOeN = 1'b0;
    for (k = 47; k >= 0; k--) begin
      hostBit = frame[k];
      #160 linkClk = 1'b1;
      #160 linkClk = 1'b0;
    end
    hostOeN = 1'b1;
    for (k = 0; k < 8 && !seen; k++) begin
      #160 linkClk = 1'b1;
      #159 seen = !cmdIn;
      #1 linkClk = 1'b0;
    end
    for (k = nBits - 2; seen && k >= 0; k--) begin
      #160 linkClk = 1'b1;
      #159 resp[k] = cmdIn;
      #1 linkClk = 1'b0;
    end
    // Spare clocks so the device releases the line
    repeat (4) begin
      #160 linkClk = 1'b1;
      #160 linkClk = 1'b0;
    end
  endtask
endmodule

// ---- test/managed_nand_card_registers_bench.sv ----
// Self-checking bench for the card register bank.
// Assumes the host model owns the link clock and command wire.
`timescale 1ns/100ps
module managed_nand_card_registers_bench;
  import card_regs_pkg::*;
  localparam int PWR = 2000; // Short power-up for simulation
  localparam logic [31:0] SERIAL = 32'h1234_5678; // Arbitrary serial
  logic clk_sys, rst, linkClk, cmdIn, cmdOut, cmdOeN, powerUpDone, seen;
  logic [2:0] cardState;
  logic [15:0] relativeAddress, driverStage, addr, drv;
  logic [14:0] prog;
  logic [135:0] resp;
  logic [127:0] idExp;
  int error_cnt = 0;
  int check_count = 0;
  managed_nand_card_registers #(.POWERUP_COUNT(PWR), .PRODUCT_SERIAL(SERIAL)) managed_nand_card_registers_inst (
    .clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .cmdIn(cmdIn), .cmdOut(cmdOut), .cmdOeN(cmdOeN),
    .powerUpDone(powerUpDone), .cardState(cardState), .relativeAddress(relativeAddress), .driverStage(driverStage));
  card_host_model card_host_model_inst (.linkClk(linkClk), .cmdIn(cmdIn), .cmdOut(cmdOut), .cmdOeN(cmdOeN));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Response presence is its own kind of result
  task automatic chk_seen(input string what, input logic exp);
    chk(what, {127'h0, exp}, {127'h0, seen});
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input int n);
    card_host_model_inst.xfer(idx, arg, n, resp, seen);
  endtask
  // Fixed and programmable parts of the card-specific data
  task automatic chk_csd(input logic [14:0] p);
    cmd(CMD_SEND_CSD, {addr, 16'h0000}, 136);
    chk("csd seen", 1'b1, seen);
    chk("csd rates", {8'hff, 8'hff, 8'h32, 12'h1f5, 4'h9, 4'h0}, resp[119:76]);
    chk("csd currents", {3'h3, 3'h7, 3'h3, 3'h7}, resp[61:50]);
    chk("csd groups", {5'h1f, 5'h1c, 5'h00, 1'b1}, resp[46:31]);
    chk("csd write len", {4'h9, 1'b0}, resp[25:21]);
    chk("csd prog", p, resp[15:1]);
    chk("csd bit0", 1'b1, resp[0]);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Watchdog, about five times the expected run
  initial begin
    #3000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    void'($urandom(24));
    addr = 16'($urandom_range(65535, 2));
    drv = 16'($urandom);
    prog = 15'($urandom);
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("address reset", 16'h0001, relativeAddress);
    chk("drive reset", 16'h0404, driverStage);
    chk("power busy", 1'b0, powerUpDone);
    cmd(CMD_SEND_OP, 32'h40ff8080, 48);
    chk("busy bit", 1'b0, resp[39]);
    repeat (PWR) @(posedge clk_sys);
    cmd(CMD_SEND_OP, 32'h40ff8080, 48);
    chk("op cond", {1'b1, 2'b10, 5'h00, 9'h1ff, 7'h00, 1'b1, 7'h00}, resp[39:8]);
    chk("ready", StReady, cardState);
    chk("power done", 1'b1, powerUpDone);
    chk("op tail", {7'h7f, 1'b1}, resp[7:0]);
    cmd(CMD_ALL_CID, 32'h0, 136);
    idExp = {MAKER_CODE, 6'h00, DEVICE_PACKAGE_KIND, OEM_APPLICATION_CODE, PRODUCT_NAME,
             PRODUCT_REVISION, SERIAL, MANUFACTURING_DATE, 8'h01};
    idExp[7:1] = card_host_model_inst.crc7(idExp >> 8, 120);
    chk("identity", idExp, resp[127:0]);
    cmd(CMD_SET_ADDR, {addr, 16'h0000}, 48);
    chk("addr status", {19'h0, 4'h2, 1'b1, 8'h00}, resp[39:8]);
    chk("address", addr, relativeAddress);
    cmd(CMD_SET_DRV, {drv, 16'h0000}, 48);
    chk_seen("drive quiet", 1'b0);
    chk("drive", drv, driverStage);
    cmd(CMD_SEND_CSD, {~addr, 16'h0000}, 136);
    chk_seen("foreign address", 1'b0);
    cmd(CMD_PROG_CSD, {16'h0000, prog, 1'b0}, 48);
    chk_csd(15'h0000);
    cmd(CMD_SELECT, {addr, 16'h0000}, 48);
    chk("transfer", StTransfer, cardState);
    cmd(CMD_STATUS, {addr, 16'h0000}, 48);
    chk("xfer status", {19'h0, 4'h4, 1'b1, 8'h00}, resp[39:8]);
    // Start bit was consumed by the presence probe, so bit 47 stays zero as sent
    chk("status crc", card_host_model_inst.crc7({88'h0, resp[47:8]}, 40), resp[7:1]);
    chk("status end", 1'b1, resp[0]);
    cmd(CMD_PROG_CSD, {16'h0000, prog, 1'b0}, 48);
    cmd(CMD_SELECT, 32'h0000_0000, 48);
    chk("deselect", StStandby, cardState);
    chk_csd(prog);
    // Addressed identity read, the only path to the second identity command
    cmd(CMD_SEND_CID, {addr, 16'h0000}, 136);
    chk_seen("identity seen", 1'b1);
    chk("identity again", idExp, resp[127:0]);
    cmd(CMD_GO_IDLE, 32'h0, 48);
    chk("idle", StIdle, cardState);
    chk("address reload", 16'h0001, relativeAddress);
    report_and_stop();
  end
endmodule
